// >>> hw/bcs_pkg.sv
// bcs_pkg: shared constants and carrier types of the charge sequencer
package bcs_pkg;
   // clock rate
   localparam int unsigned CLK_HZ        = 100_000_000;
   // safety timer lengths in seconds
   localparam int unsigned PRECHG_SEC    = 1800;   // 30 minutes
   localparam int unsigned FASTCHG_SEC   = 18000;  // 5 hours
   // one-second tick divider, cycles per second
   localparam int unsigned TICK_CYC      = CLK_HZ;
   // battery detect settling time in microseconds
   localparam int unsigned DETECT_US     = 100;
   localparam int unsigned DETECT_CYC    = DETECT_US * (CLK_HZ / 1_000_000);
   // slowed-timer weight: while current is reduced a tick counts 1/SLOW
   localparam logic [3:0]  SLOW_DIV      = 4'h2;
   // regulator select codes
   localparam logic        REG_SEL_2V2   = 1'b0;
   localparam logic        REG_SEL_3V0   = 1'b1;
   // switch type codes
   localparam logic        SW_SLIDER     = 1'b0;
   localparam logic        SW_BUTTON     = 1'b1;
   // pre-charge current as fraction of fast current, tenths
   localparam logic [3:0]  PRE_TENTHS    = 4'h1;
   localparam logic [3:0]  FULL_TENTHS   = 4'ha;

   // sequencer states
   typedef enum logic [3:0] {
      BCS_POWERUP  = 4'h0,
      BCS_IDLE     = 4'h1,
      BCS_DETECT   = 4'h2,
      BCS_PRECHG   = 4'h3,
      BCS_FASTCHG  = 4'h4,
      BCS_TAPER    = 4'h5,
      BCS_DONE     = 4'h6,
      BCS_RECHG    = 4'h7,
      BCS_DAMAGED  = 4'h8,
      BCS_FAULT    = 4'h9,
      BCS_SLEEP    = 4'ha
   } bcs_state_t;

   // analog comparator results
   typedef struct packed {
      logic bat_above_short;   // battery above short threshold
      logic bat_above_exit;    // above pre-charge exit threshold
      logic bat_at_reg;        // at regulation voltage
      logic bat_below_rch;     // below regulation minus recharge margin
      logic therm_above_lvl;   // thermistor sense above absent level
      logic below_term;        // taper current below termination
   } bcs_sense_t;

   // loops holding the current below set point
   typedef struct packed {
      logic thermal;           // junction thermal regulation
      logic power_limit;       // dynamic power limit loop
      logic low_input;         // low input voltage loop
   } bcs_limit_t;

   // commands to the analog charger stage
   typedef struct packed {
      logic       test_src_on; // battery test current source
      logic       charge_on;   // power stage enabled
      logic       cv_mode;     // constant voltage regulation
      logic [3:0] i_tenths;    // current target in tenths of fast current
      logic       i_scaled;    // extra scale-down from thermal loop
      logic       therm_mon_on;// thermistor monitoring enabled
   } bcs_drive_t;
endpackage : bcs_pkg

// >>> hw/bcs_sync.sv
// bcs_sync: two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module bcs_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta;   // first stage, read only by second stage

   // two stages, reset to zero
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule : bcs_sync
`default_nettype wire

// >>> hw/bcs_timer.sv
// bcs_timer: seconds safety timer with weighted ticks for slowed running
`timescale 1ns/1ps
`default_nettype none
module bcs_timer #(
   parameter int unsigned TICK = 100_000_000  // cycles per second
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // control
   input  wire logic        clear_in,   // restart from zero
   input  wire logic        run_in,     // count while high
   input  wire logic        slow_in,    // current reduced: run slower
   input  wire logic [15:0] limit_in,   // expiry in seconds
   // status
   output logic             expired_out
);
   typedef struct packed {
      logic [31:0] sub;     // cycle count inside one second
      logic [3:0]  frac;    // slowed tick accumulator
      logic [15:0] secs;    // elapsed seconds
      logic        done;    // sticky expiry
   } bcs_tmr_t;

   bcs_tmr_t st;
   bcs_tmr_t next_st;

   // next-state: a slowed second only counts every SLOW_DIV ticks
   always_comb begin
      next_st = st;
      if (clear_in) begin
         next_st = '0;
      end else if (run_in && !st.done) begin
         if (st.sub >= 32'(TICK - 1)) begin
            next_st.sub = '0;
            if (slow_in) begin
               // proportional stretch, trade precision for a tiny counter
               if (st.frac >= bcs_pkg::SLOW_DIV - 4'h1) begin
                  next_st.frac = '0;
                  next_st.secs = st.secs + 16'h1;
               end else begin
                  next_st.frac = st.frac + 4'h1;
               end
            end else begin
               next_st.secs = st.secs + 16'h1;
            end
         end else begin
            next_st.sub = st.sub + 32'h1;
         end
         if (next_st.secs >= limit_in) begin
            next_st.done = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired_out = st.done;
endmodule : bcs_timer
`default_nettype wire

// >>> hw/bcs_charge_seq.sv
// bcs_charge_seq: charge sequencer top with status and regulator control
//
// Contract
// - test current, battery present above short level
// - stays below short level: damaged, no charge
// - thermistor absent when sense above level
// - thermistor monitor only while charging and present
// - phases: pre-charge, fast charge, taper
// - thermal limit reduces current in all phases
// - pre-charge at one tenth, lower when thermal
// - exit threshold crossed: full fast current
// - regulation voltage reached: constant voltage taper
// - below termination current: stop, status released
// - no termination while any limit loop active
// - termination threshold unscaled in thermal regulation
// - after done, below recharge level: check removal
// - battery present: recharge until regulation voltage
// - pre-charge 30 min, fast 5 h timers
// - fast-charge timers slow under current reduction
// - pre-charge timer expiry signals fault
// - status on pre/fast; off recharge, overvoltage, sleep
// - regulator select low 2.2 V, high 3.0 V
// - thermal shutdown in current limit: sleep, regulator off; ignored during power-up
// - power-up first, then follow switch type
// - switch type low slider, high push-button
`timescale 1ns/1ps
`default_nettype none
module bcs_charge_seq #(
   parameter int unsigned TICK_CYC   = bcs_pkg::TICK_CYC,   // cycles/second
   parameter int unsigned DETECT_CYC = bcs_pkg::DETECT_CYC, // detect wait
   parameter int unsigned PRE_SEC    = bcs_pkg::PRECHG_SEC, // pre-charge
   parameter int unsigned FAST_SEC   = bcs_pkg::FASTCHG_SEC // fast charge
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rstn_in,
   // analog comparators, asynchronous to clk_in
   input  wire bcs_pkg::bcs_sense_t sense_in,
   input  wire bcs_pkg::bcs_limit_t limit_in,
   input  wire logic              input_overvoltage_in,
   input  wire logic              input_present_in,
   input  wire logic              regulator_thermal_shutdown_in,
   input  wire logic              regulator_current_limit_in,
   // configuration pins, asynchronous
   input  wire logic              switch_type_select_in,
   input  wire logic              regulator_voltage_select_in,
   input  wire logic              power_on_request_in,
   input  wire logic              charge_restart_in,
   // analog stage commands
   output bcs_pkg::bcs_drive_t    drive_out,
   output logic                   regulator_enable_out,
   output logic                   regulator_3v0_out,
   output logic                   push_button_mode_out,
   // open-drain status pin: oe low while pulling
   output logic                   charge_status_n_out,
   output logic                   charge_status_n_oe_n_out,
   // status
   output bcs_pkg::bcs_state_t    state_out,
   output logic                   charge_fault_out,
   output logic                   battery_damaged_out,
   output logic                   thermistor_present_out
);
   // synchronised inputs
   bcs_pkg::bcs_sense_t sn;
   bcs_pkg::bcs_limit_t lm;
   logic                input_overvoltage;        // input overvoltage
   logic                vin_ok;     // input power present
   logic                reg_tsd;    // regulator thermal shutdown
   logic                reg_ilim;   // regulator in current limit
   logic                switch_type_select;     // switch type level
   logic                vsel;       // regulator voltage select level
   logic                pwr_req;    // power-on request
   logic                restart;    // restart after fault

   // all pins pass two flops before use
   bcs_sync #(.W(6)) u_sync_sense (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in (sense_in),
      .sync_out (sn)
   );
   bcs_sync #(.W(3)) u_sync_limit (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in (limit_in),
      .sync_out (lm)
   );
   bcs_sync #(.W(8)) u_sync_misc (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in ({input_overvoltage_in, input_present_in,
                  regulator_thermal_shutdown_in, regulator_current_limit_in,
                  switch_type_select_in, regulator_voltage_select_in,
                  power_on_request_in, charge_restart_in}),
      .sync_out ({input_overvoltage, vin_ok, reg_tsd, reg_ilim, switch_type_select, vsel,
                  pwr_req, restart})
   );

   // whole sequencer state
   typedef struct packed {
      bcs_pkg::bcs_state_t st;       // sequencer state
      logic [31:0]         cnt;      // detect settle counter
      logic                therm_ok; // thermistor found at detect
      logic                fault;    // sticky charge fault
      logic                damaged;  // battery failed detection
      logic                recheck;  // detect run is a removal check
      logic                sw_mode;  // latched switch type
      logic                v3;       // regulator select latched
      logic                reg_on;   // regulator enable
   } bcs_seq_t;

   bcs_seq_t s;
   bcs_seq_t next_s;

   // derived conditions
   logic any_limit;     // current held below set point
   logic charging;      // power stage should be on
   logic pre_exp;       // pre-charge timer expired
   logic fast_exp;      // fast-charge timer expired
   logic in_pre;
   logic in_fast;

   assign any_limit = lm.thermal | lm.power_limit | lm.low_input;
   assign in_pre    = (s.st == bcs_pkg::BCS_PRECHG);
   assign in_fast   = (s.st == bcs_pkg::BCS_FASTCHG) ||
                      (s.st == bcs_pkg::BCS_TAPER);
   assign charging  = in_pre || in_fast || (s.st == bcs_pkg::BCS_RECHG);

   // pre-charge timer, runs only in pre-charge
   bcs_timer #(.TICK(TICK_CYC)) u_pre_tmr (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .clear_in    (!in_pre),
      .run_in      (in_pre),
      .slow_in     (1'b0),
      .limit_in    (16'(PRE_SEC)),
      .expired_out (pre_exp)
   );
   // fast-charge timer, slowed while any loop cuts the current
   bcs_timer #(.TICK(TICK_CYC)) u_fast_tmr (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .clear_in    (!in_fast),
      .run_in      (in_fast),
      .slow_in     (any_limit),
      .limit_in    (16'(FAST_SEC)),
      .expired_out (fast_exp)
   );

   // next-state logic of the sequencer
   always_comb begin
      next_s = s;
      // regulator thermal shutdown in current limit forces sleep from any state but power-up
      if (reg_tsd && reg_ilim && s.st != bcs_pkg::BCS_POWERUP) begin
         next_s.st     = bcs_pkg::BCS_SLEEP;
         next_s.reg_on = 1'b0;
      end else if (input_overvoltage && (charging || s.st == bcs_pkg::BCS_DETECT)) begin
         // overvoltage drops charging, detect again once cleared
         next_s.st = bcs_pkg::BCS_IDLE;
      end else begin
         unique case (s.st)
            bcs_pkg::BCS_POWERUP: begin
               // power-up: latch straps after the pin syncs fill
               next_s.v3      = vsel;
               next_s.sw_mode = switch_type_select;
               next_s.reg_on  = 1'b1;
               next_s.fault   = 1'b0;
               next_s.cnt     = s.cnt + 32'h1;
               if (s.cnt >= 32'h2) begin
                  next_s.st = bcs_pkg::BCS_IDLE;
               end
            end
            bcs_pkg::BCS_IDLE: begin
               // wait for input power, then check battery
               next_s.cnt     = '0;
               next_s.recheck = 1'b0;
               if (vin_ok && !input_overvoltage) begin
                  next_s.st = bcs_pkg::BCS_DETECT;
               end
            end
            bcs_pkg::BCS_DETECT: begin
               // test current on, let terminal settle then judge
               next_s.cnt = s.cnt + 32'h1;
               if (s.cnt >= 32'(DETECT_CYC - 1)) begin
                  next_s.cnt      = '0;
                  next_s.therm_ok = !sn.therm_above_lvl;
                  if (sn.bat_above_short) begin
                     next_s.damaged = 1'b0;
                     if (s.recheck) begin
                        next_s.st = bcs_pkg::BCS_RECHG;
                     end else if (sn.bat_above_exit) begin
                        next_s.st = bcs_pkg::BCS_FASTCHG;
                     end else begin
                        next_s.st = bcs_pkg::BCS_PRECHG;
                     end
                  end else begin
                     next_s.damaged = 1'b1;
                     next_s.st      = bcs_pkg::BCS_DAMAGED;
                  end
               end
            end
            bcs_pkg::BCS_PRECHG: begin
               // exit threshold wins over a timer ending the same cycle
               if (sn.bat_above_exit) begin
                  next_s.st = bcs_pkg::BCS_FASTCHG;
               end else if (pre_exp) begin
                  next_s.fault = 1'b1;
                  next_s.st    = bcs_pkg::BCS_FAULT;
               end
            end
            bcs_pkg::BCS_FASTCHG: begin
               if (fast_exp) begin
                  next_s.fault = 1'b1;
                  next_s.st    = bcs_pkg::BCS_FAULT;
               end else if (sn.bat_at_reg) begin
                  next_s.st = bcs_pkg::BCS_TAPER;
               end
            end
            bcs_pkg::BCS_TAPER: begin
               // termination blocked while any loop holds current down
               if (sn.below_term && !any_limit) begin
                  next_s.st = bcs_pkg::BCS_DONE;
               end else if (fast_exp) begin
                  next_s.fault = 1'b1;
                  next_s.st    = bcs_pkg::BCS_FAULT;
               end
            end
            bcs_pkg::BCS_DONE: begin
               // monitor battery; drop below margin starts removal check
               if (sn.bat_below_rch) begin
                  next_s.recheck = 1'b1;
                  next_s.cnt     = '0;
                  next_s.st      = bcs_pkg::BCS_DETECT;
               end
            end
            bcs_pkg::BCS_RECHG: begin
               if (sn.bat_at_reg) begin
                  next_s.recheck = 1'b0;
                  next_s.st      = bcs_pkg::BCS_DONE;
               end
            end
            bcs_pkg::BCS_DAMAGED: begin
               // never charge a shorted pack; leave on input loss or forced sleep
               if (!vin_ok) begin
                  next_s.st = bcs_pkg::BCS_IDLE;
               end
            end
            bcs_pkg::BCS_FAULT: begin
               // fault holds until restart, input removal or forced sleep
               if (restart || !vin_ok) begin
                  next_s.fault = 1'b0;
                  next_s.st    = bcs_pkg::BCS_IDLE;
               end
            end
            bcs_pkg::BCS_SLEEP: begin
               // regulator off; only a power request restarts power-up
               if (pwr_req) begin
                  next_s.st = bcs_pkg::BCS_POWERUP;
               end
            end
            default: begin
               // illegal code recovers through power-up
               next_s.st = bcs_pkg::BCS_POWERUP;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s    <= '0;
         s.st <= bcs_pkg::BCS_POWERUP;
      end else begin
         s <= next_s;
      end
   end

   // analog stage commands, registered
   bcs_pkg::bcs_drive_t next_drv;
   bcs_pkg::bcs_drive_t drv;

   // drive decode from next state so commands align with state
   always_comb begin
      next_drv = '0;
      next_drv.test_src_on  = (next_s.st == bcs_pkg::BCS_DETECT);
      next_drv.therm_mon_on = (next_s.st == bcs_pkg::BCS_PRECHG ||
                               next_s.st == bcs_pkg::BCS_FASTCHG ||
                               next_s.st == bcs_pkg::BCS_TAPER ||
                               next_s.st == bcs_pkg::BCS_RECHG) &&
                              next_s.therm_ok;
      // thermal loop scales current in every phase
      next_drv.i_scaled = lm.thermal;
      unique case (next_s.st)
         bcs_pkg::BCS_PRECHG: begin
            next_drv.charge_on = 1'b1;
            next_drv.i_tenths  = bcs_pkg::PRE_TENTHS;
         end
         bcs_pkg::BCS_FASTCHG, bcs_pkg::BCS_RECHG: begin
            next_drv.charge_on = 1'b1;
            next_drv.i_tenths  = bcs_pkg::FULL_TENTHS;
         end
         bcs_pkg::BCS_TAPER: begin
            // termination comparator stays on its fixed level
            next_drv.charge_on = 1'b1;
            next_drv.cv_mode   = 1'b1;
            next_drv.i_tenths  = bcs_pkg::FULL_TENTHS;
         end
         default: begin
            next_drv.charge_on = 1'b0;
         end
      endcase
   end

   // command register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         drv <= '0;
      end else begin
         drv <= next_drv;
      end
   end

   // status switch: conducts in pre-charge, fast charge and taper only
   logic stat_on;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stat_on <= 1'b0;
      end else begin
         stat_on <= (next_s.st == bcs_pkg::BCS_PRECHG ||
                     next_s.st == bcs_pkg::BCS_FASTCHG ||
                     next_s.st == bcs_pkg::BCS_TAPER) && !input_overvoltage;
      end
   end

   // outputs
   assign drive_out                = drv;
   assign regulator_enable_out     = s.reg_on;
   assign regulator_3v0_out        = (s.v3 == bcs_pkg::REG_SEL_3V0);
   assign push_button_mode_out     = (s.sw_mode == bcs_pkg::SW_BUTTON);
   assign charge_status_n_out      = 1'b0;       // only ever pulls low
   assign charge_status_n_oe_n_out = !stat_on;
   assign state_out                = s.st;
   assign charge_fault_out         = s.fault;
   assign battery_damaged_out      = s.damaged;
   assign thermistor_present_out   = s.therm_ok;
endmodule : bcs_charge_seq
`default_nettype wire

// >>> tb/bcs_charge_seq_assertions.sv
// bcs_charge_seq_assertions: port checks of the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module bcs_charge_seq_assertions (
   // clock and reset
   input wire logic                clk_in,
   input wire logic                rstn_in,
   // watched ports
   input wire bcs_pkg::bcs_limit_t limit_in,
   input wire bcs_pkg::bcs_drive_t drive_out,
   input wire logic                regulator_enable_out,
   input wire logic                regulator_3v0_out,
   input wire logic                push_button_mode_out,
   input wire logic                charge_status_n_oe_n_out,
   input wire bcs_pkg::bcs_state_t state_out,
   input wire logic                charge_fault_out,
   input wire logic                battery_damaged_out,
   input wire logic                thermistor_present_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // limit loop held past the two-flop sync
   sequence limit_held;
      (state_out == bcs_pkg::BCS_TAPER && |limit_in) [*4];
   endsequence
   sequence hot_charge;
      (drive_out.charge_on && limit_in.thermal) [*4];
   endsequence
   a_term_blocked: assert property (
      limit_held |=> state_out != bcs_pkg::BCS_DONE)
      else $error("termination under a limit loop");
   a_thermal_scale: assert property (
      hot_charge |-> drive_out.i_scaled)
      else $error("thermal loop did not scale current");
   a_pre_tenth: assert property (
      state_out == bcs_pkg::BCS_PRECHG |-> drive_out.i_tenths == 4'h1)
      else $error("pre-charge level wrong");
   a_fast_full: assert property (
      state_out == bcs_pkg::BCS_FASTCHG |-> drive_out.i_tenths == 4'ha
      && drive_out.charge_on && !drive_out.cv_mode)
      else $error("fast charge drive wrong");
   a_taper_cv: assert property (
      state_out == bcs_pkg::BCS_TAPER |-> drive_out.cv_mode)
      else $error("taper without voltage mode");
   a_status_on: assert property (
      state_out inside {bcs_pkg::BCS_PRECHG, bcs_pkg::BCS_FASTCHG}
      |-> !charge_status_n_oe_n_out)
      else $error("status switch off while charging");
   a_status_off: assert property (
      state_out inside {bcs_pkg::BCS_RECHG, bcs_pkg::BCS_SLEEP,
      bcs_pkg::BCS_DONE} |-> charge_status_n_oe_n_out)
      else $error("status switch on when it must be off");
   a_mon_gate: assert property (
      drive_out.therm_mon_on |-> drive_out.charge_on && thermistor_present_out)
      else $error("thermistor monitor on out of charge");
   a_damaged_off: assert property (
      battery_damaged_out || charge_fault_out |-> !drive_out.charge_on)
      else $error("charging a damaged or faulted cell");
   a_sleep_reg: assert property (
      state_out == bcs_pkg::BCS_SLEEP |-> !regulator_enable_out)
      else $error("regulator on in sleep");
   a_straps_held: assert property (
      $past(state_out) != bcs_pkg::BCS_POWERUP
      |-> $stable(regulator_3v0_out) && $stable(push_button_mode_out))
      else $error("strap moved after power-up");
endmodule : bcs_charge_seq_assertions
`default_nettype wire

// >>> tb/bcs_battery_model.sv
// bcs_battery_model: battery, thermistor and status lamp of the charger
`timescale 1ns/1ps
`default_nettype none
module bcs_battery_model (
   // bench controls, level 0 deep .. 3 full
   input  wire logic [1:0]          lvl_in,
   input  wire logic                good_in,   // cell not shorted
   input  wire logic                therm_in,  // thermistor fitted
   input  wire logic                term_in,   // taper current decayed
   // sequencer side
   input  wire bcs_pkg::bcs_drive_t drive_in,
   input  wire logic                stat_in,
   input  wire logic                stat_oe_n_in,
   output bcs_pkg::bcs_sense_t      sense_out,
   output logic                     stat_pin_out  // lamp node, pulled up
);
   // a shorted cell never climbs above the short level
   assign sense_out.bat_above_short = good_in;
   assign sense_out.bat_above_exit  = good_in && lvl_in != 2'h0;
   assign sense_out.bat_at_reg      = good_in && lvl_in == 2'h3;
   assign sense_out.bat_below_rch   = lvl_in < 2'h2;
   assign sense_out.therm_above_lvl = !therm_in;
   // current only decays once the stage regulates voltage
   assign sense_out.below_term = term_in && drive_in.cv_mode;
   // released switch: the lamp pull-up wins
   assign stat_pin_out = stat_oe_n_in ? 1'b1 : stat_in;
endmodule : bcs_battery_model
`default_nettype wire

// >>> tb/bcs_charge_seq_tb.sv
// bcs_charge_seq_tb: charge sequencer walk through all phases and faults
`timescale 1ns/1ps
`default_nettype none
module bcs_charge_seq_tb;
   logic clk_in, rstn_in, input_overvoltage, present, tsd, ilim, sw, vsel, restart;
   logic [1:0] lvl;
   logic good, therm, term, reg_en, v3, pbm, st_o, st_oe_n, pin;
   logic fault, dmg, tp;
   bcs_pkg::bcs_sense_t sense;
   bcs_pkg::bcs_limit_t limit;
   bcs_pkg::bcs_drive_t drv;
   bcs_pkg::bcs_state_t st;
   int error_cnt = 0;
   int tests_run = 0;
   // short counts: 10 cycles/s, 3 s pre-charge, 20 s fast charge
   bcs_charge_seq #(.TICK_CYC(10), .DETECT_CYC(4), .PRE_SEC(3),
      .FAST_SEC(20)) i_bcs_charge_seq (.clk_in(clk_in),
      .rstn_in(rstn_in), .sense_in(sense), .limit_in(limit),
      .input_overvoltage_in(input_overvoltage), .input_present_in(present),
      .regulator_thermal_shutdown_in(tsd),
      .regulator_current_limit_in(ilim), .switch_type_select_in(sw),
      .regulator_voltage_select_in(vsel), .power_on_request_in(1'b0),
      .charge_restart_in(restart), .drive_out(drv),
      .regulator_enable_out(reg_en), .regulator_3v0_out(v3),
      .push_button_mode_out(pbm), .charge_status_n_out(st_o),
      .charge_status_n_oe_n_out(st_oe_n), .state_out(st),
      .charge_fault_out(fault), .battery_damaged_out(dmg),
      .thermistor_present_out(tp));
   bcs_battery_model i_bcs_battery_model (.lvl_in(lvl), .good_in(good),
      .therm_in(therm), .term_in(term), .drive_in(drv), .stat_in(st_o),
      .stat_oe_n_in(st_oe_n), .sense_out(sense), .stat_pin_out(pin));
   // free-running 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // one place for every comparison
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // bounded wait for a state
   task automatic wst(input bcs_pkg::bcs_state_t s);
      for (int i = 0; i < 500 && st !== s; i++) @(negedge clk_in);
      chk(st, s);
   endtask : wst
   task automatic wrap_up;
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // hang guard, well above the ~550 cycle run
   initial begin
      #40000;
      error_cnt++;
      wrap_up();
   end
   // main sequence, inputs change at negedge
   initial begin
      {rstn_in, input_overvoltage, present, tsd, ilim, restart, term} = 7'h0;
      {sw, vsel, good, therm} = 4'hf;
      limit = '0;
      lvl = 2'h1;
      repeat (12) @(negedge clk_in);
      rstn_in = 1'b1;
      wst(bcs_pkg::BCS_IDLE);
      chk(4'(v3), 4'h1);
      chk(4'(pbm), 4'h1);
      chk(4'(reg_en), 4'h1);
      present = 1'b1;
      wst(bcs_pkg::BCS_DETECT);
      chk(4'(drv.test_src_on), 4'h1);
      wst(bcs_pkg::BCS_FASTCHG);
      chk(drv.i_tenths, 4'ha);
      chk(4'(pin), 4'h0);
      chk(4'({tp, drv.therm_mon_on}), 4'h3);
      lvl = 2'h3;
      wst(bcs_pkg::BCS_TAPER);
      limit.thermal = 1'b1;
      term = 1'b1;
      repeat (20) @(negedge clk_in);
      chk(st, bcs_pkg::BCS_TAPER);
      chk(4'(drv.i_scaled), 4'h1);
      limit = '0;
      wst(bcs_pkg::BCS_DONE);
      chk(4'({pin, drv.charge_on}), 4'h2);
      term = 1'b0;
      lvl = 2'h1;
      wst(bcs_pkg::BCS_RECHG);
      chk(4'(pin), 4'h1);
      lvl = 2'h3;
      wst(bcs_pkg::BCS_DONE);
      // deep cell: pre-charge then its timer runs out
      input_overvoltage = 1'b1;
      lvl = 2'h0;
      wst(bcs_pkg::BCS_IDLE);
      input_overvoltage = 1'b0;
      wst(bcs_pkg::BCS_PRECHG);
      chk(drv.i_tenths, 4'h1);
      wst(bcs_pkg::BCS_FAULT);
      chk(4'(fault), 4'h1);
      restart = 1'b1;
      repeat (4) @(negedge clk_in);
      restart = 1'b0;
      wst(bcs_pkg::BCS_PRECHG);
      chk(4'(fault), 4'h0);
      input_overvoltage = 1'b1;
      wst(bcs_pkg::BCS_IDLE);
      chk(4'(pin), 4'h1);
      // slowed fast timer: 200 cycles plain, 400 with a limit loop
      input_overvoltage = 1'b0;
      lvl = 2'h1;
      limit.power_limit = 1'b1;
      wst(bcs_pkg::BCS_FASTCHG);
      repeat (300) @(negedge clk_in);
      chk(st, bcs_pkg::BCS_FASTCHG);
      wst(bcs_pkg::BCS_FAULT);
      chk(4'({fault, drv.charge_on}), 4'h2);
      limit = '0;
      present = 1'b0;
      good = 1'b0;
      wst(bcs_pkg::BCS_IDLE);
      present = 1'b1;
      wst(bcs_pkg::BCS_DAMAGED);
      chk(4'({dmg, drv.charge_on}), 4'h2);
      {tsd, ilim} = 2'h3;
      wst(bcs_pkg::BCS_SLEEP);
      chk(4'({reg_en, pin}), 4'h1);
      wrap_up();
   end
endmodule : bcs_charge_seq_tb
bind bcs_charge_seq bcs_charge_seq_assertions i_chk (.clk_in, .rstn_in,
   .limit_in, .drive_out, .regulator_enable_out, .regulator_3v0_out,
   .push_button_mode_out, .charge_status_n_oe_n_out, .state_out,
   .charge_fault_out, .battery_damaged_out, .thermistor_present_out);
`default_nettype wire
